/* File: ospc_defs.svh */
// Offsets, field positions, reset values and timing counts for the oscillator
// source and PLL configuration block. Assumes a 10 MHz system clock.
`ifndef OSPC_DEFS_SVH
`define OSPC_DEFS_SVH

`define OSPC_MAP_OFF 12'h064
`define OSPC_CFG_OFF 12'h060
`define OSPC_STAT_OFF 12'h068
`define OSPC_MASK_OFF 12'h06C
`define OSPC_PLL_POWER_OFF_BIT 13
`define OSPC_OEN_BIT 12
`define OSPC_BYPASS_BIT 11
`define OSPC_PLL_CHECK_EN_BIT 10
`define OSPC_CRYSTAL_SEL_HI 9
`define OSPC_CRYSTAL_SEL_LO 6
`define OSPC_SRC_HI 5
`define OSPC_SRC_LO 4
`define OSPC_IOVER_BIT 3
`define OSPC_MOVER_BIT 2
`define OSPC_IOFF_BIT 1
`define OSPC_MOFF_BIT 0
`define OSPC_CFG_RESET 32'h00003AC0
`define OSPC_CFG_WMASK 32'h00003FFF
`define OSPC_CRYSTAL_SEL_RSVD_MAX 4'h3
`define OSPC_OD_HI 15
`define OSPC_OD_LO 14
`define OSPC_F_HI 13
`define OSPC_F_LO 5
`define OSPC_R_HI 4
`define OSPC_R_LO 0
`define OSPC_CLK_MHZ 10
`define OSPC_CHECK_WINDOW_US 100
`define OSPC_CHECK_CYCLES (`OSPC_CHECK_WINDOW_US * `OSPC_CLK_MHZ)
`define OSPC_CNT_W 11
`define OSPC_ST_PLL 2
`define OSPC_ST_IOSC 1
`define OSPC_ST_MOSC 0
`define OSPC_SLVERR 2'h2
`define OSPC_OKAY 2'h0

`endif

/* File: ospc_pkg.sv */
// Types shared by the oscillator source and PLL configuration block.
// Assumes ospc_defs.svh is on the include path.
package ospc_pkg;
  typedef enum logic [1:0] {OSC_MAIN, OSC_INT, OSC_INT_DIV4, OSC_RSVD} ospc_src_t;
  typedef enum logic [1:0] {PLL_POWER_DOWN, PLL_NORMAL, PLL_OUT_OFF} ospc_pll_mode_t;
  // PLL programming word presented by the translation register
  typedef struct packed {
    logic [1:0] od;
    logic [8:0] f;
    logic [4:0] r;
  } ospc_pll_set_t;
  // Analog-side controls
  typedef struct packed {
    logic main_osc_off;
    logic int_osc_off;
    ospc_src_t osc_source_sel;
    logic pll_power_off;
    logic pll_output_enable_n;
    logic pll_bypass;
    ospc_pll_mode_t pll_mode;
  } ospc_ctrl_t;
  // Liveness ticks from each checked clock, already in the system domain
  typedef struct packed {
    logic pll_tick;
    logic int_osc_tick;
    logic main_osc_tick;
  } ospc_alive_t;
endpackage

/* File: ospc_crystal_sel_rom.sv */
// Crystal code to PLL settings table with registered read data.
// Assumes the caller waits one enabled clock for the data to follow the code.
`timescale 1ns/1ps
`default_nettype none
module ospc_crystal_sel_rom (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [3:0] code,
  output ospc_pkg::ospc_pll_set_t data
);
  import ospc_pkg::*;
  ospc_pll_set_t rom_value;

  // Settings aim each crystal at a 200 MHz VCO; reserved codes read as zero
  always_comb begin
    unique case (code)
      4'h4: rom_value = '{od: 2'h0, f: 9'h0DF, r: 5'h03};
      4'h5: rom_value = '{od: 2'h0, f: 9'h0D8, r: 5'h03};
      4'h6: rom_value = '{od: 2'h0, f: 9'h031, r: 5'h00};
      4'h7: rom_value = '{od: 2'h0, f: 9'h060, r: 5'h01};
      4'h8: rom_value = '{od: 2'h0, f: 9'h0A1, r: 5'h03};
      4'h9: rom_value = '{od: 2'h0, f: 9'h027, r: 5'h00};
      4'hA: rom_value = '{od: 2'h0, f: 9'h04D, r: 5'h01};
      4'hB: rom_value = '{od: 2'h0, f: 9'h063, r: 5'h02};
      4'hC: rom_value = '{od: 2'h0, f: 9'h07F, r: 5'h03};
      4'hD: rom_value = '{od: 2'h0, f: 9'h068, r: 5'h03};
      4'hE: rom_value = '{od: 2'h0, f: 9'h018, r: 5'h00};
      4'hF: rom_value = '{od: 2'h0, f: 9'h02F, r: 5'h01};
      default: rom_value = '0;
    endcase
  end

  // Registered read port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data <= '0;
    end else if (ce) begin
      data <= rom_value;
    end
  end
endmodule
`default_nettype wire

/* File: ospc_top.sv */
// Oscillator source selection, crystal code and PLL configuration with
// clock verification timers, behind an AXI4-Lite slave.
// Assumes liveness ticks arrive synchronous to aclk from the analog side.
// A low ce freezes every register, bus handshakes included.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ospc_defs.svh"
module ospc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ospc_pkg::ospc_alive_t alive,
  output ospc_pkg::ospc_ctrl_t ctrl,
  output ospc_pkg::ospc_pll_set_t pll_set,
  output logic irq
);
  import ospc_pkg::*;

  // Registers and write holding stage
  logic [31:0] cfg_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_have_reg;
  logic w_have_reg;

  // Translation reload tracking
  logic [3:0] last_crystal_sel_reg;
  logic map_valid_reg;
  logic reload_reg;
  ospc_pll_set_t rom_data;

  // Watchdog and flag wiring
  logic [2:0] fail_pulse;
  logic [2:0] check_en;
  logic [2:0] tick_vec;
  logic [2:0] status_next;

  // Bus decode and next values
  logic [31:0] cfg_next;
  logic [31:0] rd_next;
  logic [1:0] rresp_next;
  logic wr_fire;
  logic wr_cfg;
  logic wr_mask;
  logic wr_mapped;
  logic rd_fire;
  logic stat_read;

  // Decoded configuration fields
  logic [3:0] crystal_sel;
  logic [1:0] src_field;
  ospc_src_t src_eff;
  ospc_pll_mode_t mode_next;

  // Fields of the configuration word
  assign crystal_sel = cfg_reg[`OSPC_CRYSTAL_SEL_HI:`OSPC_CRYSTAL_SEL_LO];
  assign src_field = cfg_reg[`OSPC_SRC_HI:`OSPC_SRC_LO];

  // Each watchdog is enabled by its own bit and fed by its own clock's tick
  assign check_en[`OSPC_ST_PLL] = cfg_reg[`OSPC_PLL_CHECK_EN_BIT];
  assign check_en[`OSPC_ST_IOSC] = cfg_reg[`OSPC_IOVER_BIT];
  assign check_en[`OSPC_ST_MOSC] = cfg_reg[`OSPC_MOVER_BIT];
  assign tick_vec[`OSPC_ST_PLL] = alive.pll_tick;
  assign tick_vec[`OSPC_ST_IOSC] = alive.int_osc_tick;
  assign tick_vec[`OSPC_ST_MOSC] = alive.main_osc_tick;

  // Write fires once both address and data are held; response slot must be free
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign stat_read = rd_fire && (s_axi_araddr == `OSPC_STAT_OFF);

  // Write address channel: one beat held until the write completes
  // Ready drops for the cycle after a beat is taken, so no beat is taken twice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      s_axi_awready <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
    end
  end

  // Write data channel, independent of address order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
      s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Byte-lane merge into the configuration word; unused bits stay zero
  always_comb begin
    cfg_next = cfg_reg;
    for (int i = 0; i < 4; i++) begin
      if (w_strb_reg[i]) begin
        cfg_next[i*8 +: 8] = w_data_reg[i*8 +: 8];
      end
    end
    cfg_next = cfg_next & `OSPC_CFG_WMASK;
  end

  // Write decode of the held address; read-only offsets answer OKAY, data dropped
  assign wr_cfg = wr_fire && (aw_addr_reg == `OSPC_CFG_OFF);
  assign wr_mask = wr_fire && (aw_addr_reg == `OSPC_MASK_OFF);
  assign wr_mapped = (aw_addr_reg == `OSPC_CFG_OFF) || (aw_addr_reg == `OSPC_MASK_OFF)
                     || (aw_addr_reg == `OSPC_STAT_OFF) || (aw_addr_reg == `OSPC_MAP_OFF);

  // Configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= `OSPC_CFG_RESET; // power-down, bypass, 6 MHz code
    end else if (ce && wr_cfg) begin
      cfg_reg <= cfg_next; // off bits and source take effect
    end
  end

  // Interrupt mask; only byte lane 0 carries flag bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= '0;
    end else if (ce && wr_mask && w_strb_reg[0]) begin
      mask_reg <= w_data_reg[2:0];
    end
  end

  // Write response: unmapped offsets answer SLVERR and the data is discarded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OSPC_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `OSPC_OKAY : `OSPC_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; reserved fields read as zero
  always_comb begin
    rd_next = '0;
    rresp_next = `OSPC_OKAY;
    unique case (s_axi_araddr)
      `OSPC_CFG_OFF: rd_next = cfg_reg;
      `OSPC_MAP_OFF: begin
        rd_next[`OSPC_OD_HI:`OSPC_OD_LO] = pll_set.od;
        rd_next[`OSPC_F_HI:`OSPC_F_LO] = pll_set.f;
        rd_next[`OSPC_R_HI:`OSPC_R_LO] = pll_set.r;
      end
      `OSPC_STAT_OFF: rd_next[2:0] = status_reg;
      `OSPC_MASK_OFF: rd_next[2:0] = mask_reg;
      default: rresp_next = `OSPC_SLVERR;
    endcase
  end

  // Read channel: one read in flight, answer one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `OSPC_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_next;
        s_axi_rresp <= rresp_next;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !rd_fire && !s_axi_arready;
    end
  end

  // Translation table lookup
  ospc_crystal_sel_rom u_rom (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .code(crystal_sel),
    .data(rom_data)
  );

  // Watch the crystal code; a change or the end of reset schedules a reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_crystal_sel_reg <= `OSPC_CRYSTAL_SEL_RSVD_MAX;
      reload_reg <= 1'b0;
      map_valid_reg <= 1'b0;
    end else if (ce) begin
      last_crystal_sel_reg <= crystal_sel;
      reload_reg <= (crystal_sel != last_crystal_sel_reg) || !map_valid_reg;
      map_valid_reg <= 1'b1;
    end
  end

  // Translation register loads after the table has settled on the new code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_set <= '0;
    end else if (ce && reload_reg) begin
      pll_set <= rom_data; // reserved codes give zero
    end
  end

  // Per-clock verification timers; a missing tick for a full window is a failure
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_check
      logic [`OSPC_CNT_W-1:0] cnt_reg;
      logic expired;
      // A clock slower than one tick per window reads as stopped
      assign expired = (cnt_reg == `OSPC_CNT_W'(`OSPC_CHECK_CYCLES - 1));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_reg <= '0;
        end else if (ce) begin
          if (!check_en[g] || tick_vec[g]) begin
            cnt_reg <= '0; // disabled checks stay idle
          end else if (expired) begin
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      end
      assign fail_pulse[g] = check_en[g] && !tick_vec[g] && expired;
    end
  endgenerate

  // Next flag state: a read clears, a failure in the same cycle still sets
  assign status_next = (stat_read ? 3'h0 : status_reg) | fail_pulse;

  // Sticky failure flags; a read clears them but a new failure wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
    end else if (ce) begin
      status_reg <= status_next;
    end
  end

  // Level interrupt from unmasked flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status_next & mask_reg);
    end
  end

  // Effective source: reserved code falls back to the main oscillator
  always_comb begin
    unique case (src_field)
      2'h1: src_eff = OSC_INT;
      2'h2: src_eff = OSC_INT_DIV4; // the only internal choice fit for the PLL
      default: src_eff = OSC_MAIN;
    endcase
  end

  // PLL mode: power-off dominates the output enable
  always_comb begin
    if (cfg_reg[`OSPC_PLL_POWER_OFF_BIT]) begin
      mode_next = PLL_POWER_DOWN;
    end else if (!cfg_reg[`OSPC_OEN_BIT]) begin
      mode_next = PLL_NORMAL;
    end else begin
      mode_next = PLL_OUT_OFF;
    end
  end

  // Registered analog-side controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '{main_osc_off: 1'b0,
                int_osc_off: 1'b0,
                osc_source_sel: OSC_MAIN,
                pll_power_off: 1'b1,
                pll_output_enable_n: 1'b1,
                pll_bypass: 1'b1,
                pll_mode: PLL_POWER_DOWN}; // PLL parked until software runs it
    end else if (ce) begin
      ctrl.main_osc_off <= cfg_reg[`OSPC_MOFF_BIT];
      ctrl.int_osc_off <= cfg_reg[`OSPC_IOFF_BIT];
      ctrl.osc_source_sel <= src_eff;
      ctrl.pll_power_off <= cfg_reg[`OSPC_PLL_POWER_OFF_BIT];
      ctrl.pll_output_enable_n <= cfg_reg[`OSPC_OEN_BIT];
      ctrl.pll_bypass <= cfg_reg[`OSPC_BYPASS_BIT]; // high: oscillator feeds system
      ctrl.pll_mode <= mode_next;
    end
  end
endmodule
`default_nettype wire

/* File: ospc_monitor.sv */
// Port checker for the oscillator source and PLL configuration block.
// Assumes one aclk domain and no bus request offered while ce is low.
`timescale 1ns/1ps
`default_nettype none
module ospc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire ospc_pkg::ospc_ctrl_t ctrl,
  input wire ospc_pkg::ospc_pll_set_t pll_set,
  input wire logic irq
);
  import ospc_pkg::*;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset values seen at the first edge after release
  property p_rst_pll;
    $rose(aresetn) |-> ctrl.pll_power_off && ctrl.pll_output_enable_n && ctrl.pll_bypass;
  endproperty
  a_rst_pll: assert property (p_rst_pll) else $error("pll not parked");
  property p_rst_osc;
    $rose(aresetn) |-> !ctrl.main_osc_off && !ctrl.int_osc_off && ctrl.osc_source_sel == OSC_MAIN;
  endproperty
  a_rst_osc: assert property (p_rst_osc) else $error("osc reset wrong");
  property p_rst_irq;
    $rose(aresetn) |-> !irq [*8];
  endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
  property p_rst_map;
    $rose(aresetn) |-> pll_set == 16'h0000;
  endproperty
  a_rst_map: assert property (p_rst_map) else $error("map not cleared");
  // The reset code names a real crystal, so the reset load gives nonzero settings
  property p_rst_load;
    $rose(aresetn) |-> ##2 pll_set != 16'h0000;
  endproperty
  a_rst_load: assert property (p_rst_load) else $error("map not loaded");
  // Mode table: power-off wins over the output enable
  property p_mode_pd;
    ctrl.pll_power_off |-> ctrl.pll_mode == PLL_POWER_DOWN;
  endproperty
  a_mode_pd: assert property (p_mode_pd) else $error("pll not down");
  property p_mode_run;
    !ctrl.pll_power_off && !ctrl.pll_output_enable_n |-> ctrl.pll_mode == PLL_NORMAL;
  endproperty
  a_mode_run: assert property (p_mode_run) else $error("pll not normal");
  property p_src_ok;
    ctrl.osc_source_sel != OSC_RSVD;
  endproperty
  a_src_ok: assert property (p_src_ok) else $error("reserved source out");
  // Bus answers: a late answer would stall software
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
endmodule
bind ospc_top ospc_monitor u_ospc_monitor (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .ctrl, .pll_set, .irq);
`default_nettype wire

/* File: ospc_analog_model.sv */
// Analog side: liveness ticks of the three checked clocks.
// Assumes ctrl from the block; a stopped clock gives no ticks.
`timescale 1ns/1ps
`default_nettype none
module ospc_analog_model (
  input wire logic aclk,
  input wire ospc_pkg::ospc_ctrl_t ctrl,
  output var ospc_pkg::ospc_alive_t alive = '0
);
  import ospc_pkg::*;
  logic [1:0] div_reg = 2'h0;
  // Sparse ticks, as a synchronised slow clock would give
  always @(posedge aclk) begin
    div_reg <= div_reg + 2'h1;
    alive.main_osc_tick <= (div_reg == 2'h0) && !ctrl.main_osc_off;
    alive.int_osc_tick <= (div_reg == 2'h1) && !ctrl.int_osc_off;
    alive.pll_tick <= (div_reg == 2'h2) && (ctrl.pll_mode == PLL_NORMAL);
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Register-level bench for the oscillator and PLL block over AXI4-Lite.
// Assumes the analog model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ospc_defs.svh"
module tb_top;
  import ospc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rv;
  ospc_alive_t alive;
  ospc_ctrl_t ctrl;
  ospc_pll_set_t pll_set, pll6;
  int err_total = 0, n_compared = 0;
  logic [31:0] cfg_tab [5] = '{32'h38C0, 32'h3CC0, 32'h06CD, 32'h06CE, 32'h06CD};
  logic [2:0] msk_tab [5] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h6};
  logic [2:0] st_tab [5] = '{3'h0, 3'h4, 3'h1, 3'h2, 3'h1};
  logic iq_tab [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  // Clock enable is dropped once, in the freeze test
  ospc_top u_ospc_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .alive(alive), .ctrl(ctrl), .pll_set(pll_set), .irq(irq));
  ospc_analog_model u_ospc_analog_model (.aclk(aclk), .ctrl(ctrl), .alive(alive));
  // 100 ns period
  initial begin
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Flags are taken at the falling edge, where they equal what the next rise samples
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask
  // Cuts a hang short well past the expected run
  initial begin
    #3000000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(negedge aclk);
    rd(`OSPC_CFG_OFF, rv, rs);
    chk("cfg reset", rv, `OSPC_CFG_RESET);
    chk("crystal_sel reset", 32'(rv[9:6]), 32'hB);
    chk("pll_power_off reset", 32'(rv[13]), 32'h1);
    rd(`OSPC_MASK_OFF, rv, rs);
    chk("mask reset", rv, 32'h0);
    pll6 = pll_set;
    chk("map loaded", 32'(pll6 != 16'h0), 32'h1);
    rd(`OSPC_MAP_OFF, rv, rs);
    chk("map reset", rv, 32'(pll6));
    $display("test reset done");
    // Run mode, every source code, off bits following the code
    for (int i = 0; i < 4; i++) begin
      wr(`OSPC_CFG_OFF, 32'h02C0 + 32'(i * 17), rs);
      chk("cfg resp", 32'(rs), 32'(`OSPC_OKAY));
      @(negedge aclk);
      chk("src", 32'(ctrl.osc_source_sel), (i == 3) ? 32'h0 : 32'(i));
      chk("offs", {30'h0, ctrl.int_osc_off, ctrl.main_osc_off}, 32'(i));
      chk("mode", 32'(ctrl.pll_mode), 32'(PLL_NORMAL));
      chk("bypass", 32'(ctrl.pll_bypass), 32'h0);
      rd(`OSPC_CFG_OFF, rv, rs);
      chk("cfg back", rv, 32'h02C0 + 32'(i * 17));
    end
    wr(`OSPC_CFG_OFF, 32'h2AC0, rs);
    @(negedge aclk);
    chk("mode pd", 32'(ctrl.pll_mode), 32'(PLL_POWER_DOWN));
    chk("bypass on", 32'(ctrl.pll_bypass), 32'h1);
    wr(`OSPC_CFG_OFF, 32'h12C0, rs);
    @(negedge aclk);
    chk("mode out off", 32'(ctrl.pll_mode), 32'(PLL_OUT_OFF));
    chk("oen off", 32'(ctrl.pll_output_enable_n), 32'h1);
    $display("test source done");
    // Every crystal code, reload after each change
    for (int i = 0; i < 16; i++) begin
      wr(`OSPC_CFG_OFF, 32'h3800 | 32'(i << 6), rs);
      repeat (4) @(negedge aclk);
      rd(`OSPC_MAP_OFF, rv, rs);
      chk("map port", rv, 32'(pll_set));
      if (i < 4) chk("map rsvd", rv, 32'h0);
      if (i >= 4) chk("map set", 32'(rv != 32'h0), 32'h1);
      if (i == 11) chk("map 6mhz", rv, 32'(pll6));
    end
    $display("test crystal done");
    wr(12'h0F0, 32'hFFFFFFFF, rs);
    chk("unmapped wr", 32'(rs), 32'(`OSPC_SLVERR));
    rd(12'h0F0, rv, rs);
    chk("unmapped rd", 32'(rs), 32'(`OSPC_SLVERR));
    $display("test refusal done");
    // Watchdogs: off, PLL, main, internal, then masked
    for (int k = 0; k < 5; k++) begin
      wr(`OSPC_MASK_OFF, 32'(msk_tab[k]), rs);
      wr(`OSPC_CFG_OFF, cfg_tab[k], rs);
      rd(`OSPC_STAT_OFF, rv, rs);
      repeat (1100) @(negedge aclk);
      chk("irq", 32'(irq), 32'(iq_tab[k]));
      rd(`OSPC_STAT_OFF, rv, rs);
      chk("status", rv, 32'(st_tab[k]));
      rd(`OSPC_STAT_OFF, rv, rs);
      chk("status clr", rv, 32'h0);
    end
    $display("test check done");
    // Clock enable low: the PLL watchdog must not advance while frozen
    wr(`OSPC_MASK_OFF, 32'h7, rs);
    wr(`OSPC_CFG_OFF, 32'h3CC0, rs);
    rd(`OSPC_STAT_OFF, rv, rs);
    @(posedge aclk);
    ce <= 1'b0;
    repeat (1100) @(negedge aclk);
    chk("frozen irq", 32'(irq), 32'h0);
    @(posedge aclk);
    ce <= 1'b1;
    rd(`OSPC_STAT_OFF, rv, rs);
    chk("frozen status", rv, 32'h0);
    repeat (1100) @(negedge aclk);
    rd(`OSPC_STAT_OFF, rv, rs);
    chk("thawed status", rv, 32'h4);
    $display("test freeze done");
    report_and_stop();
  end
endmodule
`default_nettype wire
